// file: verilog/ptg_pkg.sv
/*
  Shared constants and types for the pulse train generator.
  Assumes an AXI4-Lite master with 32-bit data and byte addresses.
*/
`default_nettype none
package ptg_pkg;
  localparam int CNT_W = 32;
  localparam int AW = 8;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_DELAY = 8'h04;
  localparam logic [AW-1:0] OFS_HIGH = 8'h08;
  localparam logic [AW-1:0] OFS_LOW = 8'h0C;
  localparam logic [AW-1:0] OFS_LEN = 8'h10;
  localparam logic [AW-1:0] OFS_NSAMP = 8'h14;
  localparam logic [AW-1:0] OFS_STAT = 8'h18;
  // Control fields
  localparam int C_ARM = 0;
  localparam int C_MODE = 2;
  localparam int C_FALL = 5;
  localparam int C_TRIG = 6;
  localparam int C_PAUSE = 7;
  localparam int C_PLVL = 8;
  localparam int C_EVERY = 9;
  localparam int C_REGEN = 10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0200;
  localparam logic [31:0] ONE_RST = 32'h0000_0001;
  // Status fields
  localparam int S_RUN = 0;
  localparam int S_UFL = 1;
  localparam int S_WAITING = 2;
  localparam int S_FLUSH = 8;
  localparam int S_CNT = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    M_RETRIG = 3'b000, M_CONT = 3'b001, M_IMP_FIN = 3'b010,
    M_IMP_CONT = 3'b011, M_SC_FIN = 3'b100, M_SC_CONT = 3'b101
  } mode_t;
  typedef enum logic [1:0] {
    R_STD = 2'b00, R_FIFO = 2'b01, R_NONE = 2'b10
  } regen_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WAIT = 3'b001, ST_DELAY = 3'b010,
    ST_HIGH = 3'b011, ST_LOW = 3'b100, ST_NEXT = 3'b101
  } state_t;
  typedef struct packed {
    logic [CNT_W-1:0] idle;
    logic [CNT_W-1:0] active;
  } sample_t;
endpackage
`default_nettype wire

// file: verilog/pulse_train_gen.sv
/*
  Counter output pulse generator: retriggerable pulses, continuous
  trains with pause, and FIFO buffered trains.
  Assumes AXI4-Lite master on aclk; source, gate and sample clock
  pins are asynchronous and at most aclk/4 in rate.
*/
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
// How it works
// - Each start trigger gives one pulse or a configured series of pulses.
// - Trigger delay and pulse width count active source edges.
// - Setting picks initial delay on every trigger or first only.
// - Gate ignored during generation; then wait for next trigger.
// - No pause trigger while gate serves as start trigger.
// - Two source ticks separate trigger and first used source edge; the code uses the first tick after gate sync.
// - Continuous train waits programmed source edges after arming.
// - High and low counts set apart; source edge rising or falling.
// - Continuous train starts on arming or on gate start trigger.
// - Gate as pause trigger suspends generation while active.
// - Output frequency equals source frequency over high plus low.
// - Implicit buffered mode takes one idle/active pair per pulse.
// - Sample clock lets current pulse finish, then next sample applies.
// - Static spec ignored in implicit; runs before first sample clock.
// - Finite implicit makes one pulse per pair, back to back.
// - Continuous buffered modes run until stopped or until a needed sample finds the FIFO empty.
// - Finite sample clocked keeps last spec until stopped.
// - FIFO regeneration replays stored buffer, accepting no new data.
// - Empty FIFO during generation flags underflow.
`timescale 1ns/1ps
`default_nettype none
module pulse_train_gen import ptg_pkg::*; #(
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timing pins
  input wire logic src_in,
  input wire logic gate_in,
  input wire logic sclk_in,
  // Sample stream
  input wire logic s_valid,
  input wire sample_t s_data,
  output logic s_ready,
  // Status outputs
  output logic pulse_out,
  output logic running,
  output logic underflow
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [2:0] src_s_q, gate_s_q, sclk_s_q;
  logic [31:0] ctrl_q, delay_q, high_q, low_q, len_q, nsamp_q;
  logic [AW-1:0] aw_addr_q, ar_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_full_q, w_full_q, wr_go, wr_hit, flush;
  logic [31:0] rd_val;
  logic rd_hit;
  sample_t mem [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] fcnt_q, fcnt_d;
  logic push, take, avail, lock;
  state_t st_q;
  logic [CNT_W-1:0] cnt_q, cur_low_q, cur_high_q, pcnt_q, issued_q;
  logic first_q, arm_prev_q, pend_q;
  logic src_tick, gate_rise, sclk_rise, paused, tick_ok, last;
  logic arm_rise, implicit, sclked, finite, fin_done, need_smp;
  mode_t mode;
  regen_t regen;

  // Two-flop synchronisers plus edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_s_q <= 3'h0;
      gate_s_q <= 3'h0;
      sclk_s_q <= 3'h0;
    end else if (ce) begin
      src_s_q <= {src_s_q[1:0], src_in};
      gate_s_q <= {gate_s_q[1:0], gate_in};
      sclk_s_q <= {sclk_s_q[1:0], sclk_in};
    end
  end

  // Decoded control and edges
  always_comb begin
    mode = mode_t'(ctrl_q[C_MODE +: 3]);
    regen = regen_t'(ctrl_q[C_REGEN +: 2]);
    src_tick = ctrl_q[C_FALL] ? (~src_s_q[1] & src_s_q[2])
                              : (src_s_q[1] & ~src_s_q[2]);
    gate_rise = gate_s_q[1] & ~gate_s_q[2];
    sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    // pause only when gate is no trigger
    paused = ctrl_q[C_PAUSE] & ~ctrl_q[C_TRIG]
             & (gate_s_q[1] == ctrl_q[C_PLVL]);
    tick_ok = src_tick & ~paused;
    last = (cnt_q <= CNT_W'(1));
    arm_rise = ctrl_q[C_ARM] & ~arm_prev_q;
    implicit = (mode == M_IMP_FIN) | (mode == M_IMP_CONT);
    sclked = (mode == M_SC_FIN) | (mode == M_SC_CONT);
    finite = (mode == M_IMP_FIN) | (mode == M_SC_FIN);
    fin_done = finite & (issued_q == nsamp_q);
    need_smp = implicit ? ~fin_done : (sclked & pend_q & ~fin_done);
    avail = (fcnt_q != '0);
    take = (st_q == ST_NEXT) & need_smp & avail;
  end

  // AXI write channel: address and data in either order
  assign wr_go = aw_full_q & w_full_q & ~bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
        aw_full_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_full_q <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Byte lane merge
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  assign wr_hit = (aw_addr_q <= OFS_STAT) && (aw_addr_q[1:0] == 2'h0);
  assign flush = wr_go & (aw_addr_q == OFS_STAT) & w_strb_q[1]
                 & w_data_q[S_FLUSH];

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      delay_q <= 32'h0000_0000;
      high_q <= ONE_RST;
      low_q <= ONE_RST;
      len_q <= ONE_RST;
      nsamp_q <= 32'h0000_0000;
    end else if (ce && wr_go) begin
      case (aw_addr_q)
        OFS_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
        OFS_DELAY: delay_q <= merge(delay_q, w_data_q, w_strb_q);
        OFS_HIGH: high_q <= merge(high_q, w_data_q, w_strb_q);
        OFS_LOW: low_q <= merge(low_q, w_data_q, w_strb_q);
        OFS_LEN: len_q <= merge(len_q, w_data_q, w_strb_q);
        OFS_NSAMP: nsamp_q <= merge(nsamp_q, w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  // Read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (ar_addr_q)
      OFS_CTRL: rd_val = ctrl_q;
      OFS_DELAY: rd_val = delay_q;
      OFS_HIGH: rd_val = high_q;
      OFS_LOW: rd_val = low_q;
      OFS_LEN: rd_val = len_q;
      OFS_NSAMP: rd_val = nsamp_q;
      OFS_STAT: begin
        rd_val[S_RUN] = running;
        rd_val[S_UFL] = underflow;
        rd_val[S_WAITING] = (st_q == ST_WAIT);
        rd_val[S_CNT +: PW+1] = fcnt_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // AXI read channel, data one cycle after address
  logic ar_pend_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      ar_pend_q <= 1'b0;
      ar_addr_q <= '0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        ar_addr_q <= araddr;
        ar_pend_q <= 1'b1;
        arready <= 1'b0;
      end
      if (ar_pend_q) begin
        ar_pend_q <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Sample FIFO
  // stored buffer locked while armed
  assign lock = (regen == R_FIFO) & ctrl_q[C_ARM];
  assign push = s_valid & s_ready;
  always_comb begin
    fcnt_d = fcnt_q;
    if (push) fcnt_d = fcnt_d + (PW+1)'(1);
    if (take && regen != R_FIFO) fcnt_d = fcnt_d - (PW+1)'(1);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      fcnt_q <= '0;
      s_ready <= 1'b0;
    end else if (ce) begin
      if (flush) begin
        wp_q <= '0;
        rp_q <= '0;
        fcnt_q <= '0;
        s_ready <= ~lock;
      end else begin
        if (push) wp_q <= wp_q + PW'(1);
        if (take && regen == R_FIFO)
          rp_q <= ({1'b0, rp_q} + (PW+1)'(1) == fcnt_q) ? '0 : rp_q + PW'(1);
        else if (take)
          rp_q <= rp_q + PW'(1);
        fcnt_q <= fcnt_d;
        s_ready <= ~lock & (fcnt_d < FULL);
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (ce && push) mem[wp_q] <= s_data;
  end

  // Sample clock pending flag, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
    end else if (ce) begin
      if (st_q == ST_IDLE)
        pend_q <= 1'b0;
      else if (sclked && sclk_rise)
        pend_q <= 1'b1;
      else if (take || (st_q == ST_NEXT && sclked && fin_done))
        pend_q <= 1'b0;
    end
  end

  // Underflow flag, W1C, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underflow <= 1'b0;
    end else if (ce) begin
      // empty when a sample is needed
      if (st_q == ST_NEXT && need_smp && !avail)
        underflow <= 1'b1;
      else if (wr_go && aw_addr_q == OFS_STAT && w_strb_q[0]
               && w_data_q[S_UFL])
        underflow <= 1'b0;
    end
  end

  // Generation state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      cur_low_q <= '0;
      cur_high_q <= '0;
      pcnt_q <= '0;
      issued_q <= '0;
      first_q <= 1'b0;
      arm_prev_q <= 1'b0;
    end else if (ce) begin
      arm_prev_q <= ctrl_q[C_ARM];
      if (!ctrl_q[C_ARM]) begin
        st_q <= ST_IDLE;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (arm_rise) begin
              first_q <= 1'b1;
              pcnt_q <= '0;
              issued_q <= '0;
              cur_low_q <= low_q;
              cur_high_q <= high_q;
              cnt_q <= delay_q;
              if (ctrl_q[C_TRIG]) st_q <= ST_WAIT;
              else if (implicit) st_q <= ST_NEXT;
              else st_q <= ST_DELAY;
            end
          end
          ST_WAIT: begin
            // counting begins on ticks after sync
            if (gate_rise) begin
              first_q <= 1'b0;
              pcnt_q <= '0;
              if (implicit) begin
                st_q <= ST_NEXT;
              // delay every trigger or first only
              end else if (first_q || ctrl_q[C_EVERY]) begin
                cnt_q <= delay_q;
                st_q <= ST_DELAY;
              end else begin
                cnt_q <= cur_high_q;
                st_q <= ST_HIGH;
              end
            end
          end
          ST_DELAY: begin
            if (tick_ok && last) begin
              cnt_q <= cur_high_q;
              st_q <= ST_HIGH;
            end else if (tick_ok) begin
              cnt_q <= cnt_q - CNT_W'(1);
            end
          end
          ST_HIGH: begin
            if (tick_ok && last) begin
              pcnt_q <= pcnt_q + CNT_W'(1);
              st_q <= ST_NEXT;
            end else if (tick_ok) begin
              cnt_q <= cnt_q - CNT_W'(1);
            end
          end
          ST_LOW: begin
            if (tick_ok && last) begin
              cnt_q <= cur_high_q;
              st_q <= ST_HIGH;
            end else if (tick_ok) begin
              cnt_q <= cnt_q - CNT_W'(1);
            end
          end
          // Pulse boundary decision
          ST_NEXT: begin
            cnt_q <= cur_low_q;
            st_q <= ST_LOW;
            if (mode == M_RETRIG) begin
              // series of len pulses per trigger
              if (pcnt_q >= len_q)
                st_q <= ctrl_q[C_TRIG] ? ST_WAIT : ST_IDLE;
            end else if (implicit) begin
              if (fin_done) begin
                st_q <= ST_IDLE;
              end else if (avail) begin
                cur_low_q <= mem[rp_q].idle;
                cur_high_q <= mem[rp_q].active;
                cnt_q <= mem[rp_q].idle;
                issued_q <= issued_q + CNT_W'(1);
              end else begin
                st_q <= ST_IDLE;
              end
            end else if (sclked && need_smp) begin
              if (avail) begin
                cur_low_q <= mem[rp_q].idle;
                cur_high_q <= mem[rp_q].active;
                cnt_q <= mem[rp_q].idle;
                issued_q <= issued_q + CNT_W'(1);
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out <= 1'b0;
      running <= 1'b0;
    end else if (ce) begin
      pulse_out <= (st_q == ST_HIGH);
      running <= (st_q != ST_IDLE) && (st_q != ST_WAIT);
    end
  end
endmodule // pulse_train_gen
`default_nettype wire

// file: tb/ptg_check_asserts.sv
/*
  Port-level checker for pulse_train_gen.
  Assumes ce held high and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module ptg_check (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // Generator outputs
  input wire logic pulse_out,
  input wire logic running,
  input wire logic underflow
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answer timing
  property p_wr_ans;
    awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer off time");
  property p_rd_ans;
    arvalid && arready |=> !arready ##1 rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer off time");
  property p_b_busy;
    bvalid |-> !awready && !wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
  property p_r_busy;
    rvalid |-> !arready;
  endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
  property p_b_done;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response not retired");
  property p_r_done;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read response not retired");
  // Output and underflow behaviour
  property p_idle_low;
    !running [*2] |-> !pulse_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("output active while idle");
  property p_ufl_keep;
    underflow && awready |=> underflow;
  endproperty
  a_ufl_keep: assert property (p_ufl_keep) else $error("underflow flag lost");
  property p_ufl_stop;
    $rose(underflow) |-> ##[0:2] !running;
  endproperty
  a_ufl_stop: assert property (p_ufl_stop) else $error("run continues after underflow");
  // Main scenarios reached
  c_pulse: cover property ($rose(pulse_out));
  c_ufl: cover property ($rose(underflow));
  c_slverr: cover property (bvalid && bready && bresp == 2'h2);
endmodule // ptg_check
bind pulse_train_gen ptg_check ptg_check_inst (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .pulse_out(pulse_out),
  .running(running), .underflow(underflow)
);
`default_nettype wire

// file: tb/ptg_host.sv
/*
  Host stream model that feeds pulse specs.
  Assumes the bench calls send and sets gap between words.
*/
`timescale 1ns/1ps
`default_nettype none
module ptg_host import ptg_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sample stream
  output logic s_valid,
  output var sample_t s_data,
  input wire logic s_ready
);
  sample_t q[$];
  sample_t last = '0;
  int gap = 0;
  int w = 0;
  // Quiet stream at start
  initial begin
    s_valid = 1'b0;
    s_data = '0;
  end
  task automatic send(input logic [CNT_W-1:0] idle, input logic [CNT_W-1:0] active);
    q.push_back({idle, active});
  endtask
  always @(posedge aclk) begin
    if (s_valid && s_ready) begin
      void'(q.pop_front());
      w = gap;
    end
    if (!aresetn || w > 0 || q.size() == 0) begin
      if (w > 0) w--;
      s_valid <= 1'b0;
      s_data <= ~last;
    end else begin
      s_valid <= 1'b1;
      s_data <= q[0];
      last = q[0];
    end
  end
endmodule // ptg_host
`default_nettype wire

// file: tb/test_retriggerable_buffered_pulse_train_gen.sv
/*
  Self-checking bench for pulse_train_gen.
  Assumes source ticks every 8 aclk and the host stream model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_retriggerable_buffered_pulse_train_gen import ptg_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, s_valid, s_ready, pulse_out, running, underflow;
  logic src_in = 1'b0, gate_in = 1'b0, sclk_in = 1'b0, prev = 1'b0, p;
  sample_t s_data;
  int error_cnt = 0, n_checks = 0, cyc = 0, rises = 0, h, l, n0;
  pulse_train_gen #(.DEPTH(16)) pulse_train_gen_inst (.*);
  ptg_host ptg_host_inst (.*);
  // Clock
  always #2 aclk = ~aclk;
  // Source ticks, rise count, timeout
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) src_in <= ~src_in;
    prev <= pulse_out;
    if (pulse_out === 1'b1 && prev === 1'b0) rises <= rises + 1;
    if (cyc == 30000) begin
      $display("Error at %0t: cycles %h limit %h", $time, cyc, 30000);
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp; bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 1'b0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic gate();
    @(posedge aclk); gate_in <= 1'b1;
    wait_n(4); gate_in <= 1'b0;
  endtask
  // One sample clock pulse, four cycles wide
  task automatic sclk();
    @(posedge aclk); sclk_in <= 1'b1;
    wait_n(4); sclk_in <= 1'b0;
  endtask
  // High and low time in aclk cycles, low capped at 2000
  task automatic meas();
    int n;
    n = 0; h = 0; l = 0;
    while (pulse_out !== 1'b1 && n < 2000) begin @(posedge aclk); n++; end
    while (pulse_out === 1'b1) begin @(posedge aclk); h++; end
    while (pulse_out !== 1'b1 && l < 2000) begin @(posedge aclk); l++; end
  endtask
  task automatic t_regs();
    logic [7:0] ofs [6] = '{OFS_CTRL, OFS_DELAY, OFS_HIGH, OFS_LOW, OFS_LEN, OFS_NSAMP};
    logic [31:0] rv [6] = '{CTRL_RST, 32'h0, ONE_RST, ONE_RST, ONE_RST, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]); chk(d, rv[i]); chk(r, RESP_OKAY);
    end
    rd(8'h1C); chk(r, RESP_SLVERR); chk(d, 32'h0);
    wr(8'h21, 32'h0); chk(r, RESP_SLVERR);
    $display("Test regs done");
  endtask
  task automatic t_retrig();
    wr(OFS_DELAY, 32'h2); wr(OFS_HIGH, 32'h3); wr(OFS_LEN, 32'h1);
    wr(OFS_CTRL, 32'h0000_0241);
    wait_n(40); chk(pulse_out, 0); chk(running, 0);
    n0 = rises; gate(); wait_n(8); gate(); wait_n(200);
    chk(rises - n0, 1);
    gate(); meas(); chk(h, 24);
    chk(l, 2000);
    wr(OFS_LEN, 32'h2); n0 = rises; gate(); wait_n(300);
    chk(rises - n0, 2);
    wr(OFS_CTRL, 32'h0000_00C1); n0 = rises; gate(); wait_n(6);
    chk(rises - n0, 1);
    wait_n(200); chk(rises - n0, 2);
    wr(OFS_CTRL, 32'h0);
    $display("Test retrig done");
  endtask
  task automatic t_cont();
    wr(OFS_DELAY, 32'h3); wr(OFS_HIGH, 32'h2); wr(OFS_LOW, 32'h3);
    for (int f = 0; f < 2; f++) begin
      wr(OFS_CTRL, 32'h0000_0005 | (f << C_FALL)); n0 = rises;
      wait_n(14); chk(rises - n0, 0);
      meas(); chk(h, 16);
      chk(h + l, 40);
      wr(OFS_CTRL, 32'h0); wait_n(4); chk(pulse_out, 0);
    end
    wr(OFS_CTRL, 32'h0000_0045); n0 = rises; wait_n(150);
    chk(rises - n0, 0);
    gate(); meas(); chk(h, 16);
    wr(OFS_CTRL, 32'h0000_0185); meas(); gate_in <= 1'b1; wait_n(10);
    n0 = rises; p = pulse_out; wait_n(100);
    chk(rises - n0, 0);
    chk(pulse_out, p);
    gate_in <= 1'b0; wait_n(150); chk(rises > n0, 1);
    wr(OFS_CTRL, 32'h0);
    $display("Test cont done");
  endtask
  task automatic t_buf();
    int n;
    ptg_host_inst.gap = 2;
    wr(OFS_STAT, 32'h100); wr(OFS_NSAMP, 32'h3); wr(OFS_HIGH, 32'h9); wr(OFS_LOW, 32'h9);
    ptg_host_inst.send(2, 2); ptg_host_inst.send(3, 4); ptg_host_inst.send(2, 2);
    wait_n(40); wr(OFS_CTRL, 32'h0000_0009);
    meas(); chk(h, 16); chk(l, 24);
    meas(); chk(h, 32); chk(l, 16);
    meas(); chk(h, 16); chk(l, 2000);
    chk(running, 0);
    wr(OFS_CTRL, 32'h0); ptg_host_inst.send(2, 2); ptg_host_inst.send(2, 2); wait_n(40);
    wr(OFS_CTRL, 32'h0000_080D); n = 0;
    while (underflow !== 1'b1 && n < 1000) begin @(posedge aclk); n++; end
    chk(underflow, 1);
    rd(OFS_STAT); chk(d[S_UFL], 1);
    wr(OFS_CTRL, 32'h0); wr(OFS_STAT, 32'h2); wait_n(2); chk(underflow, 0);
    wr(OFS_STAT, 32'h100); ptg_host_inst.send(1, 1); ptg_host_inst.send(2, 1); wait_n(40);
    wr(OFS_CTRL, 32'h0000_040D); wait_n(2); chk(s_ready, 0);
    n0 = rises; wait_n(400); chk(rises - n0 > 5, 1);
    wr(OFS_CTRL, 32'h0);
    $display("Test buffered done");
  endtask
  // Sample clocked finite, then continuous running dry
  task automatic t_sclk();
    int t [4] = '{3, 2, 3, 3};
    wr(OFS_STAT, 32'h100); wr(OFS_NSAMP, 32'h3); wr(OFS_DELAY, 32'h3);
    wr(OFS_HIGH, 32'h2); wr(OFS_LOW, 32'h2);
    ptg_host_inst.send(3, 3); ptg_host_inst.send(2, 2); ptg_host_inst.send(3, 3);
    wait_n(40); wr(OFS_CTRL, 32'h0000_0011);
    meas(); chk(h, 16);
    chk(l, 16);
    for (int i = 0; i < 4; i++) begin
      sclk(); meas(); chk(l, t[i] * 8);
      meas(); chk(h, t[i] * 8);
    end
    chk(running, 1);
    chk(underflow, 0);
    wr(OFS_CTRL, 32'h0); wr(OFS_CTRL, 32'h0000_0015);
    meas(); chk(h, 16);
    sclk(); wait_n(60); chk(underflow, 1);
    wr(OFS_CTRL, 32'h0); wr(OFS_STAT, 32'h2);
    $display("Test sclk done");
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    wait_n(5);
    aresetn <= 1'b1;
    t_regs();
    t_retrig();
    t_cont();
    t_buf();
    t_sclk();
    report_and_stop();
  end
endmodule // test_retriggerable_buffered_pulse_train_gen
`default_nettype wire
